// *** logic/hcal_pkg.sv ***
// Shared constants and types for the homing and encoder block
package hcal_pkg;
	// ==========================================================
	// Wishbone register word offsets (byte addresses)
	localparam logic [7:0] HCAL_REG_CTRL   = 8'h00;
	localparam logic [7:0] HCAL_REG_CFG    = 8'h04;
	localparam logic [7:0] HCAL_REG_SPEED  = 8'h08;
	localparam logic [7:0] HCAL_REG_OFFSET = 8'h0c;
	localparam logic [7:0] HCAL_REG_STATUS = 8'h10;
	localparam logic [7:0] HCAL_REG_IRQ    = 8'h14;
	localparam logic [7:0] HCAL_REG_MASK   = 8'h18;
	localparam logic [7:0] HCAL_REG_POS    = 8'h1c;
	localparam logic [7:0] HCAL_REG_RATE   = 8'h20;
	localparam logic [7:0] HCAL_REG_CPT    = 8'h24;
	localparam logic [7:0] HCAL_REG_HALF   = 8'h28;
	// ==========================================================
	// CTRL bits (write-one actions)
	localparam int CTRL_START = 0;
	localparam int CTRL_ESTOP = 1;
	localparam int CTRL_POFF  = 2;
	localparam int CTRL_ALARM = 3;
	localparam int CTRL_SLOSS = 4;
	// CFG fields
	localparam int CFG_DIR1    = 0;
	localparam int CFG_DIR2    = 1;
	localparam int CFG_DIRF    = 2;
	localparam int CFG_DIRO    = 3;
	localparam int CFG_SRC1    = 4;
	localparam int CFG_SRC2    = 6;
	localparam int CFG_FINE    = 8;
	localparam int CFG_BLANK   = 9;
	localparam int CFG_SYNCEN  = 10;
	localparam int CFG_REVINV  = 11;
	localparam int CFG_LIMAINV = 12;
	localparam int CFG_LIMBINV = 13;
	localparam int CFG_LIMSWAP = 14;
	localparam int CFG_ENCMAIN = 15;
	localparam logic [15:0] CFG_RESET = 16'h0400;
	// Interrupt events
	localparam int EV_DONE  = 0;
	localparam int EV_LOST  = 1;
	localparam int EV_SKIP  = 2;
	localparam int NUM_EV   = 3;
	// ==========================================================
	// Timing: encoder phase rate and rate window
	localparam int CLK_HZ        = 200_000_000;
	localparam int PHASE_MAX_HZ  = 200_000;
	localparam int PHASE_MIN_CYC = CLK_HZ / (PHASE_MAX_HZ * 4);
	localparam int RATE_WIN_MS   = 100;
	localparam int RATE_WIN_CYC  = CLK_HZ / 1000 * RATE_WIN_MS;
	// End sources
	typedef enum logic [1:0] {
		SRC_LIMIT = 2'b00,
		SRC_SYNC  = 2'b01,
		SRC_REV   = 2'b10,
		SRC_NONE  = 2'b11
	} hcal_src_t;
	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_COARSE = 3'b001,
		ST_BACK   = 3'b010,
		ST_SLOW   = 3'b011,
		ST_FINE   = 3'b100,
		ST_OFFSET = 3'b101
	} hcal_state_t;
endpackage

// *** logic/hcal_sync.sv ***
// Two-flop synchroniser for a group of sensor inputs
`timescale 1ns/1ps
module hcal_sync #(
	parameter int WIDTH = 5
) (
	input  wire logic             core_clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] din,
	output logic      [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] stage1;

	// Reset follows the pins so no false edge follows release
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			stage1 <= din;
			dout   <= stage1;
		end else begin
			stage1 <= din;
			dout   <= stage1;
		end
	end
endmodule

// *** logic/hcal_quad.sv ***
// Times-four quadrature decoder with step pulses and skip detect
`timescale 1ns/1ps
module hcal_quad (
	input  wire logic core_clk,
	input  wire logic rst_b,
	input  wire logic phaseA,
	input  wire logic phaseB,
	output logic      countUp,
	output logic      countDown,
	output logic      skipErr
);
	logic [1:0] prev;
	wire  [1:0] cur = {phaseA, phaseB};
	// Gray order 00 -> 10 -> 11 -> 01 counts up (A leads)
	wire        fwd = (prev == 2'b00 && cur == 2'b10) || (prev == 2'b10 && cur == 2'b11) ||
	                  (prev == 2'b11 && cur == 2'b01) || (prev == 2'b01 && cur == 2'b00);
	wire        rev = (prev == 2'b00 && cur == 2'b01) || (prev == 2'b01 && cur == 2'b11) ||
	                  (prev == 2'b11 && cur == 2'b10) || (prev == 2'b10 && cur == 2'b00);
	wire        skip = (prev ^ cur) == 2'b11;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			prev      <= cur; // No skip flagged for the first state seen
			countUp   <= 1'b0;
			countDown <= 1'b0;
			skipErr   <= 1'b0;
		end else begin
			prev      <= cur;
			countUp   <= fwd;
			countDown <= rev;
			skipErr   <= skip;
		end
	end
endmodule

// *** logic/hcal_top.sv ***
// Homing sequencer, encoder position tracking and Wishbone registers
//
// Contract
// - Coarse search in first direction until stop
// - Back off half turn, then slow search
// - Search end from limit, sync or revolution
// - Disabled sync input is ignored entirely
// - Completed homing sets homed flag
// - Limit stop, estop moving, loss, alarm clear
// - Estop or power-off when stationary keeps flag
// - Optional fine pass until end source fires
// - Blanking ignores fine-pass end until half turn
// - Final offset move defines home
// - Decode quadrature in times-four mode
// - Keep up with 200 kHz phase rate
// - Encoder as main sensor or loss check
// - Main mode: counts position, rpm speed
// - Revolution sensor active low, invertible
// - Limit polarity and side set independently
//
// The register offsets and the Wishbone register port were chosen for this implementation.
`timescale 1ns/1ps
module hcal_top
	import hcal_pkg::*;
#(
	parameter int POS_W      = 32,
	parameter int RATE_WIN   = hcal_pkg::RATE_WIN_CYC
) (
	input  wire logic        core_clk,
	input  wire logic        rst_b,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        phase_a_input,
	input  wire logic        phase_b_input,
	input  wire logic        revSensor,
	input  wire logic        syncIn,
	input  wire logic        limitA,
	input  wire logic        limitB,
	input  wire logic        motorStep,
	output logic             motorRun,
	output logic             motorDir,
	output logic             motorSlow,
	output logic             homed_flag,
	output logic             irq
);
	import hcal_pkg::*;

	// ==========================================================
	// Input synchronisation
	logic [4:0] syncd;
	hcal_sync #(.WIDTH(5)) u_sync (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.din      ({phase_a_input, phase_b_input, revSensor, syncIn, limitA}),
		.dout     (syncd)
	);
	logic limBq1;
	logic limBs;
	// Extra limit line kept on its own pair to keep the group small
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			limBq1 <= 1'b1;
			limBs  <= 1'b1;
		end else begin
			limBq1 <= limitB;
			limBs  <= limBq1;
		end
	end

	// ==========================================================
	// Registers
	logic [15:0]      cfg;
	logic [31:0]      speeds;
	logic [POS_W-1:0] offsetDist;
	logic [31:0]      halfTurn;
	logic [15:0]      countsPerTurn;
	logic [NUM_EV-1:0] irqStat;
	logic [NUM_EV-1:0] irqMask;
	logic [POS_W-1:0] encPos;
	logic [31:0]      rpm;

	wire wbReq   = wb_cyc_i && wb_stb_i && !wb_ack_o;
	wire wbWr    = wbReq && wb_we_i && wb_sel_i[0];
	wire wrCtrl  = wbWr && wb_adr_i == HCAL_REG_CTRL;
	wire wrCfg   = wbWr && wb_adr_i == HCAL_REG_CFG;
	wire wrSpeed = wbWr && wb_adr_i == HCAL_REG_SPEED;
	wire wrOff   = wbWr && wb_adr_i == HCAL_REG_OFFSET;
	wire wrIrq   = wbWr && wb_adr_i == HCAL_REG_IRQ;
	wire wrMask  = wbWr && wb_adr_i == HCAL_REG_MASK;
	wire wrCpt   = wbWr && wb_adr_i == HCAL_REG_CPT;
	wire wrHalf  = wbWr && wb_adr_i == HCAL_REG_HALF;
	wire cmdStart = wrCtrl && wb_dat_i[CTRL_START];
	wire cmdEstop = wrCtrl && (wb_dat_i[CTRL_ESTOP] || wb_dat_i[CTRL_POFF]);
	wire cmdAlarm = wrCtrl && wb_dat_i[CTRL_ALARM];
	wire cmdSloss = wrCtrl && wb_dat_i[CTRL_SLOSS];

	// ==========================================================
	// Sensor conditioning
	wire phA     = syncd[4];
	wire phB     = syncd[3];
	wire revAct  = syncd[2] ^ ~cfg[CFG_REVINV];
	wire syncAct = cfg[CFG_SYNCEN] && syncd[1];
	wire limAAct = syncd[0] ^ cfg[CFG_LIMAINV];
	wire limBAct = limBs ^ cfg[CFG_LIMBINV];
	wire limLeft  = cfg[CFG_LIMSWAP] ? limBAct : limAAct;
	wire limRight = cfg[CFG_LIMSWAP] ? limAAct : limBAct;

	logic revPrev;
	logic syncPrev;
	wire  revEdge  = revAct && !revPrev;
	wire  syncEdge = syncAct && !syncPrev;

	// Selected source fires for the current direction; limit as level
	function automatic logic srcFire(input logic [1:0] src, input logic dir,
	                                 input logic lL, input logic lR,
	                                 input logic sE, input logic rE);
		case (src)
			SRC_LIMIT: srcFire = dir ? lR : lL;
			SRC_SYNC:  srcFire = sE;
			SRC_REV:   srcFire = rE;
			default:   srcFire = 1'b0;
		endcase
	endfunction

	// ==========================================================
	// Encoder
	logic encUp;
	logic encDown;
	logic encSkip;
	hcal_quad u_quad (
		.core_clk  (core_clk),
		.rst_b     (rst_b),
		.phaseA    (phA),
		.phaseB    (phB),
		.countUp   (encUp),
		.countDown (encDown),
		.skipErr   (encSkip)
	);

	// Position counts: encoder counts in main mode, else motor steps
	wire encMain = cfg[CFG_ENCMAIN];
	wire posInc  = encMain ? encUp : (motorStep && motorDir);
	wire posDec  = encMain ? encDown : (motorStep && !motorDir);
	wire travel  = encMain ? (encUp || encDown) : motorStep;

	// ==========================================================
	// Homing sequencer
	hcal_state_t      state;
	hcal_state_t      next_state;
	logic [POS_W-1:0] moveCnt;
	wire  inSearch = state == ST_COARSE || state == ST_SLOW || state == ST_FINE;
	wire  blanked  = state == ST_FINE && cfg[CFG_BLANK] &&
	                 moveCnt < POS_W'(halfTurn);
	wire  [1:0] curSrc = state == ST_FINE ? cfg[CFG_SRC2+:2] : cfg[CFG_SRC1+:2];
	wire  endHit = inSearch && !blanked &&
	               srcFire(curSrc, motorDir, limLeft, limRight, syncEdge, revEdge);
	// A limit hit while running is a hard stop unless the limit is the current search end source
	wire  limStop = motorRun && !(inSearch && curSrc == SRC_LIMIT) &&
	                (motorDir ? limRight : limLeft);
	wire  abort   = cmdEstop || cmdAlarm || limStop;
	wire  backDone  = state == ST_BACK && moveCnt >= POS_W'(halfTurn);
	wire  offDone   = state == ST_OFFSET && moveCnt >= offsetDist;
	wire  homeDone  = offDone && !abort;

	always_comb begin
		next_state = state;
		if (abort) begin
			next_state = ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:   if (cmdStart) next_state = ST_COARSE;
				ST_COARSE: if (endHit) next_state = ST_BACK;
				ST_BACK:   if (backDone) next_state = ST_SLOW;
				ST_SLOW:   if (endHit) next_state = cfg[CFG_FINE] ? ST_FINE : ST_OFFSET;
				ST_FINE:   if (endHit) next_state = ST_OFFSET;
				ST_OFFSET: if (offDone) next_state = ST_IDLE;
				default:   next_state = ST_IDLE;
			endcase
		end
	end

	logic next_dir;
	always_comb begin
		case (next_state)
			ST_COARSE: next_dir = cfg[CFG_DIR1];
			ST_BACK:   next_dir = !cfg[CFG_DIR1];
			ST_SLOW:   next_dir = cfg[CFG_DIR1];
			ST_FINE:   next_dir = cfg[CFG_DIRF];
			ST_OFFSET: next_dir = cfg[CFG_DIRO];
			default:   next_dir = motorDir;
		endcase
	end

	// Homed flag: set wins over nothing else; loss events drop it
	wire lost  = (cmdEstop && motorRun) || cmdAlarm || cmdSloss || limStop;
	wire [NUM_EV-1:0] events = {encSkip, lost && homed_flag, homeDone};

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state     <= ST_IDLE;
			motorRun  <= 1'b0;
			motorDir  <= 1'b0;
			motorSlow <= 1'b0;
			moveCnt   <= '0;
			revPrev   <= 1'b0;
			syncPrev  <= 1'b0;
		end else begin
			state     <= next_state;
			motorRun  <= next_state != ST_IDLE;
			motorDir  <= next_dir;
			motorSlow <= next_state == ST_SLOW || next_state == ST_FINE;
			revPrev   <= revAct;
			syncPrev  <= syncAct;
			if (next_state != state)
				moveCnt <= '0;
			else if (travel)
				moveCnt <= moveCnt + POS_W'(1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b)
			homed_flag <= 1'b0;
		else if (lost)
			homed_flag <= 1'b0;
		else if (homeDone)
			homed_flag <= 1'b1;
	end

	// ==========================================================
	// Position and speed (rpm = counts per window scaled per minute, divided by counts per turn)
	localparam int WIN_PER_MIN = 60 * 1000 / RATE_WIN_MS;
	logic [31:0]     winCnt;
	logic [31:0]     rateCnt;
	wire             winEnd = winCnt == 32'(RATE_WIN - 1);
	wire  [47:0]     rpmNum = 48'(rateCnt) * 48'(WIN_PER_MIN);
	wire  [47:0]     rpmVal = countsPerTurn == 16'h0000 ? 48'h0 : rpmNum / 48'(countsPerTurn);

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			encPos  <= '0;
			winCnt  <= 32'h0;
			rateCnt <= 32'h0;
			rpm     <= 32'h0;
		end else begin
			if (posInc)
				encPos <= encPos + POS_W'(1);
			else if (posDec)
				encPos <= encPos - POS_W'(1);
			winCnt <= winEnd ? 32'h0 : winCnt + 32'h1;
			if (winEnd) begin
				rpm     <= rpmVal[31:0];
				rateCnt <= 32'h0;
			end else if (encUp || encDown) begin
				rateCnt <= rateCnt + 32'h1;
			end
		end
	end

	// ==========================================================
	// Wishbone slave, configuration and interrupt bits
	logic [31:0] rdData;
	always_comb begin
		case (wb_adr_i)
			HCAL_REG_CFG:    rdData = {16'h0, cfg};
			HCAL_REG_SPEED:  rdData = speeds;
			HCAL_REG_OFFSET: rdData = 32'(offsetDist);
			HCAL_REG_STATUS: rdData = {24'h0, homed_flag, motorSlow, motorDir,
			                           motorRun, 1'b0, state};
			HCAL_REG_IRQ:    rdData = {29'h0, irqStat};
			HCAL_REG_MASK:   rdData = {29'h0, irqMask};
			HCAL_REG_POS:    rdData = 32'(encPos);
			HCAL_REG_RATE:   rdData = rpm;
			HCAL_REG_CPT:    rdData = {16'h0, countsPerTurn};
			HCAL_REG_HALF:   rdData = halfTurn;
			default:         rdData = 32'h0;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wb_ack_o      <= 1'b0;
			wb_dat_o      <= 32'h0;
			cfg           <= CFG_RESET;
			speeds        <= 32'h0;
			offsetDist    <= '0;
			countsPerTurn <= 16'h0;
			halfTurn      <= 32'h0;
			irqMask       <= '0;
		end else begin
			wb_ack_o <= wbReq;
			wb_dat_o <= wbReq ? rdData : 32'h0;
			if (wrCfg)   cfg           <= wb_dat_i[15:0];
			if (wrSpeed) speeds        <= wb_dat_i;
			if (wrOff)   offsetDist    <= POS_W'(wb_dat_i);
			if (wrCpt)   countsPerTurn <= wb_dat_i[15:0];
			if (wrHalf)  halfTurn      <= wb_dat_i;
			if (wrMask)  irqMask       <= wb_dat_i[NUM_EV-1:0];
		end
	end

	// Set beats a same-cycle write-one clear
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			irqStat <= '0;
			irq     <= 1'b0;
		end else begin
			irqStat <= (irqStat & ~(wrIrq ? wb_dat_i[NUM_EV-1:0] : '0)) | events;
			irq     <= |(((irqStat & ~(wrIrq ? wb_dat_i[NUM_EV-1:0] : '0)) | events) & irqMask);
		end
	end
endmodule

// *** test/hcal_top_assertions.sv ***
// Port-level assertions for the homing and encoder block
`timescale 1ns/1ps
module hcal_top_checker
	import hcal_pkg::*;
#(
	parameter int POS_W    = 32,
	parameter int RATE_WIN = 1000
) (
	input wire logic        core_clk,
	input wire logic        rst_b,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_we_i,
	input wire logic [7:0]  wb_adr_i,
	input wire logic [3:0]  wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic        wb_ack_o,
	input wire logic        motorRun,
	input wire logic        motorSlow,
	input wire logic        homed_flag,
	input wire logic        irq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// ==========================================================
	// Control write seen on the edge that takes it
	wire ctrlWr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0]
		&& wb_adr_i == HCAL_REG_CTRL;
	// ==========================================================
	// Properties
	property p_ackNext;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ackNext: assert property (p_ackNext) else $error("ack late");
	property p_ackOne;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ackOne: assert property (p_ackOne) else $error("ack too long");
	property p_datIdle;
		!wb_ack_o |-> wb_dat_o == 32'h0;
	endproperty
	a_datIdle: assert property (p_datIdle) else $error("read data without ack");
	property p_coarseFast;
		$rose(motorRun) |-> !motorSlow;
	endproperty
	a_coarseFast: assert property (p_coarseFast) else $error("search starts slow");
	property p_slowRuns;
		motorSlow |-> motorRun;
	endproperty
	a_slowRuns: assert property (p_slowRuns) else $error("slow without run");
	property p_homedStop;
		$rose(homed_flag) |-> ##[0:1] !motorRun;
	endproperty
	a_homedStop: assert property (p_homedStop) else $error("homed while moving");
	property p_keepHomed;
		ctrlWr && wb_dat_i[4:0] == 5'h06 && !motorRun && homed_flag |=> homed_flag [*2];
	endproperty
	a_keepHomed: assert property (p_keepHomed) else $error("homed lost at rest");
	property p_estopMove;
		ctrlWr && wb_dat_i[1] && motorRun |-> ##[1:2] !homed_flag && !motorRun;
	endproperty
	a_estopMove: assert property (p_estopMove) else $error("estop kept homed");
	property p_alarmLost;
		ctrlWr && wb_dat_i[3] |-> ##[1:2] !homed_flag;
	endproperty
	a_alarmLost: assert property (p_alarmLost) else $error("alarm kept homed");
	c_homed: cover property ($rose(homed_flag));
	c_slow: cover property ($rose(motorSlow));
	c_irq: cover property ($rose(irq));
endmodule

bind hcal_top hcal_top_checker #(.POS_W(POS_W), .RATE_WIN(RATE_WIN)) i_hcal_top_checker (
	.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .motorRun(motorRun), .motorSlow(motorSlow),
	.homed_flag(homed_flag), .irq(irq));

// *** test/hcal_motor_model.sv ***
// Motor with encoder, revolution sensor and limit switches
`timescale 1ns/1ps
module hcal_motor_model #(
	parameter int CNT_CYC = 250,
	parameter int START   = 40,
	parameter int LIM_R   = 1000
) (
	input  wire logic core_clk,
	input  wire logic motorRun,
	input  wire logic motorDir,
	input  wire logic motorSlow,
	output logic      phaseA,
	output logic      phaseB,
	output logic      motorStep,
	output logic      revSensor,
	output logic      limitA,
	output logic      limitB
);
	int pos = START;
	int tick = 0;
	// ==========================================================
	// Encoder: A leads B when moving right
	assign phaseA = pos[1] ^ pos[0];
	assign phaseB = pos[1];
	// Active low once every 32 counts, idle high
	assign revSensor = (pos & 16) != 16 || (pos & 15) != 0;
	assign limitA = pos <= 0;
	assign limitB = pos >= LIM_R;
	initial motorStep = 1'b0;
	// ==========================================================
	// Fast speed sits at the top phase rate, slow at half of it
	always @(posedge core_clk) begin
		motorStep <= 1'b0;
		if (!motorRun) begin
			tick <= 0;
		end else if (tick >= (motorSlow ? 2 * CNT_CYC : CNT_CYC)) begin
			tick <= 0;
			pos <= motorDir ? pos + 1 : pos - 1;
			motorStep <= 1'b1;
		end else begin
			tick <= tick + 1;
		end
	end
endmodule

// *** test/hcal_top_bench.sv ***
// Self-checking bench for the homing and encoder block
`timescale 1ns/1ps
module hcal_top_bench;
	import hcal_pkg::*;
	logic        core_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [31:0] wbWdat = 32'h0;
	logic [31:0] wbRdat;
	logic        wbAck;
	logic        syncIn = 1'b0;
	logic        phA, phB, revS, limA, limB, stepP, motorRun, motorDir, motorSlow, homed, irq;
	int          n_fail = 0;
	int          checks_done = 0;

	always #2.5 core_clk = ~core_clk;

	hcal_top #(.RATE_WIN(1000)) i_hcal_top (
		.core_clk(core_clk), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbWdat),
		.wb_dat_o(wbRdat), .wb_ack_o(wbAck), .phase_a_input(phA), .phase_b_input(phB),
		.revSensor(revS), .syncIn(syncIn), .limitA(limA), .limitB(limB),
		.motorStep(stepP), .motorRun(motorRun), .motorDir(motorDir),
		.motorSlow(motorSlow), .homed_flag(homed), .irq(irq));

	hcal_motor_model i_hcal_motor_model (
		.core_clk(core_clk), .motorRun(motorRun), .motorDir(motorDir),
		.motorSlow(motorSlow), .phaseA(phA), .phaseB(phB), .motorStep(stepP),
		.revSensor(revS), .limitA(limA), .limitB(limB));

	// ==========================================================
	// Tasks
	task automatic summarize();
		$display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int k;
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbWdat <= d;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (wbAck !== 1'b1 && k < 100);
		q = wbRdat;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (k >= 100)
			chk(32'h1, 32'h0);
	endtask

	task automatic wbWr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wbXfer(1'b1, a, d, q);
	endtask

	task automatic wbRd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wbXfer(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	// Settle a few edges so registered flags have landed
	task automatic chkBit(input int sel, input logic e);
		logic b;
		repeat (3) @(posedge core_clk);
		b = sel == 0 ? motorRun : sel == 1 ? motorSlow : sel == 2 ? homed : irq;
		chk({31'h0, b}, {31'h0, e});
	endtask

	task automatic waitHi(input int sel);
		int k;
		k = 0;
		while ((sel == 0 ? motorRun : sel == 1 ? motorSlow : homed) !== 1'b1 && k < 40000) begin
			@(posedge core_clk);
			k++;
		end
		if (k >= 40000)
			chk(32'h2, 32'h0);
	endtask

	// Sync acts on its rising edge; four cycles clears the synchroniser
	task automatic pulseSync();
		syncIn <= 1'b1;
		repeat (4) @(posedge core_clk);
		syncIn <= 1'b0;
	endtask

	// ==========================================================
	// Sequence
	initial begin
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		wbRd(HCAL_REG_CFG, {16'h0, CFG_RESET});
		wbRd(HCAL_REG_STATUS, 32'h0);
		wbRd(8'h3c, 32'h0);
		chkBit(3, 1'b0);
		wbWr(HCAL_REG_CFG, 32'h8408);
		wbWr(HCAL_REG_HALF, 32'h8);
		wbWr(HCAL_REG_OFFSET, 32'h5);
		wbWr(HCAL_REG_MASK, 32'h3);
		wbWr(HCAL_REG_CTRL, 32'h1);
		waitHi(2);
		chkBit(2, 1'b1);
		wbRd(HCAL_REG_POS, 32'(i_hcal_motor_model.pos - 40));
		wbRd(HCAL_REG_IRQ, 32'h1);
		chkBit(3, 1'b1);
		wbWr(HCAL_REG_IRQ, 32'h1);
		wbRd(HCAL_REG_IRQ, 32'h0);
		chkBit(3, 1'b0);
		wbWr(HCAL_REG_CTRL, 32'h6);
		chkBit(2, 1'b1);
		wbWr(HCAL_REG_CFG, 32'h8011);
		wbWr(HCAL_REG_CTRL, 32'h1);
		waitHi(0);
		pulseSync();
		repeat (300) @(posedge core_clk);
		chkBit(0, 1'b1);
		wbWr(HCAL_REG_CTRL, 32'h2);
		chkBit(2, 1'b0);
		chkBit(0, 1'b0);
		wbRd(HCAL_REG_IRQ, 32'h2);
		wbWr(HCAL_REG_MASK, 32'h1);
		chkBit(3, 1'b0);
		wbWr(HCAL_REG_MASK, 32'h3);
		chkBit(3, 1'b1);
		wbWr(HCAL_REG_IRQ, 32'h2);
		wbWr(HCAL_REG_CFG, 32'h879d);
		wbWr(HCAL_REG_CTRL, 32'h1);
		waitHi(0);
		repeat (1000) @(posedge core_clk);
		pulseSync();
		waitHi(1);
		repeat (500) @(posedge core_clk);
		pulseSync();
		waitHi(2);
		chkBit(2, 1'b1);
		wbWr(HCAL_REG_CTRL, 32'h8);
		chkBit(2, 1'b0);
		summarize();
	end

	initial begin
		#450000;
		n_fail++;
		$display("FAIL %0t watchdog expired", $time);
		summarize();
	end
endmodule
